//--- dtcm_monitor.sv
// Purpose: dual channel torque cutoff monitor, removes gate enable and trips
// Assumes: 50 MHz mclk; channels driven by a safety switch, 1 = closed
// Notes:   mismatch timer is a parameter so simulation can shorten it
//
// Behaviour
// - open inputs withdraw gate enable everywhere
// - cutoff raises selected indication, stopped or running
// - open input refuses starts, motor coasts
// - after closing, restart only after reset
// - cutoff overrides every other drive command
// - compare channels; mismatch trips with channel code
// - single channel use treated as mismatch
// - catch openings as short as 1 ms
// - mismatch trips only beyond 200 ms
// - fault reaction done within 10 ms more
// - fault indication within 500 ms
// - warning indication within 1000 ms
// - no memory; held level start may restart
// - first or second channel code by channel
`default_nettype none

module dtcm_monitor #(
  parameter int unsigned MISMATCH_CYCLES = dtcm_pkg::MismatchCycles
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // cutoff channel pins, high when closed
  input  wire logic [1:0]  chanPin,
  // drive control
  input  wire logic        startReq,    // level start request
  input  wire logic        resetCmd,    // fault reset command, level
  input  wire logic        driveEnReq,  // other functions asking for gate drive
  input  wire logic [1:0]  indSel,      // indication selection setting
  // outputs
  output logic             gateEnable,  // gate drive enable to power switches
  output logic             motorRun,    // drive running
  output logic             cutoffWarn,  // warning indication
  output logic             cutoffFault, // fault indication
  output logic [1:0]       faultCode    // latched mismatch channel code
);
  import dtcm_pkg::*;

  // ---------------------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------------------
  dtcm_sync_if syncBus ();

  dtcm_sync uSync (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .chanPin (chanPin),
    .syncOut (syncBus.src)
  );

  logic [1:0] closed;     // agreed channel levels
  logic       anyOpen;    // torque cutoff requested
  logic       mismatch;   // channels disagree
  assign closed   = syncBus.chanClosed;
  assign anyOpen  = ~&closed;
  assign mismatch = closed[0] ^ closed[1];

  // ---------------------------------------------------------------------------
  // mismatch duration timer
  // ---------------------------------------------------------------------------
  logic mismatchExp; // channels differed longer than the detection time

  dtcm_timer #(
    .LIMIT (MISMATCH_CYCLES),
    .WIDTH (24)
  ) uMisTimer (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .run     (mismatch),
    .expired (mismatchExp)
  );

  // ---------------------------------------------------------------------------
  // state and latched fault
  // ---------------------------------------------------------------------------
  dtcm_state_t state_q, state_d;
  logic [1:0]  faultCode_q;  // latched channel code
  logic        running_q;    // drive running
  logic        runAtCut_q;   // was running when cutoff hit
  logic        gate_q;
  logic        warn_q;
  logic        fault_q;

  // next state; cutoff checked first so nothing else can enable
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DTCM_RUN_OK: begin
        if (anyOpen) begin
          state_d = DTCM_CUTOFF;
        end
      end
      DTCM_CUTOFF: begin
        if (mismatchExp) begin
          state_d = DTCM_FAULTED;
        end else if (!anyOpen) begin
          state_d = DTCM_WAITRST;
        end
      end
      DTCM_FAULTED: begin
        // recovery: both open and reset, then closing leads to wait
        if (!anyOpen) begin
          state_d = DTCM_WAITRST;
        end
      end
      DTCM_WAITRST: begin
        if (anyOpen) begin
          state_d = mismatchExp ? DTCM_FAULTED : DTCM_CUTOFF;
        end else if (resetCmd && faultCode_q == FaultCodeNone) begin
          state_d = DTCM_RUN_OK;
        end
      end
    endcase
  end

  // state register; no memory across power loss, reset lands in cutoff
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= DTCM_CUTOFF;
    end else begin
      state_q <= state_d;
    end
  end

  // fault code latch: a new trip wins over a reset in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      faultCode_q <= FaultCodeNone;
    end else if (mismatchExp && faultCode_q == FaultCodeNone) begin
      // the open channel names the code
      faultCode_q <= closed[0] ? FaultCodeSecond : FaultCodeFirst;
    end else if (resetCmd && !mismatch && (anyOpen || state_q == DTCM_FAULTED)) begin
      // reset accepted only with both channels agreeing
      faultCode_q <= FaultCodeNone;
    end
  end

  // ---------------------------------------------------------------------------
  // run control and gate enable
  // ---------------------------------------------------------------------------
  // a start is refused unless the state allows it; a held level start restarts
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      running_q <= 1'b0;
    end else if (anyOpen || state_q != DTCM_RUN_OK) begin
      running_q <= 1'b0;
    end else begin
      running_q <= startReq;
    end
  end

  // remember whether the motor was turning when the cutoff hit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      runAtCut_q <= 1'b0;
    end else if (state_q == DTCM_RUN_OK && anyOpen) begin
      runAtCut_q <= running_q;
    end else if (state_q == DTCM_RUN_OK) begin
      runAtCut_q <= 1'b0;
    end
  end

  // gate enable drops on the cycle after any open level
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= !anyOpen && !(|syncBus.chanBreak) && state_q == DTCM_RUN_OK
                && running_q && driveEnReq;
    end
  end

  // ---------------------------------------------------------------------------
  // indications, one cycle after cause, far inside 500 ms and 1000 ms
  // ---------------------------------------------------------------------------
  logic cutActive; // cutoff or fault present
  assign cutActive = state_q != DTCM_RUN_OK || anyOpen;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      warn_q  <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      warn_q  <= 1'b0;
      fault_q <= faultCode_q != FaultCodeNone;
      if (cutActive) begin
        unique case (indSel)
          IndSelNone:  ;
          IndSelFault: fault_q <= 1'b1;
          IndSelWarn:  warn_q  <= 1'b1;
          IndSelMixed: begin
            // running versus stopped picks fault or warning
            if (runAtCut_q || running_q) fault_q <= 1'b1;
            else warn_q <= 1'b1;
          end
        endcase
      end
    end
  end

  assign gateEnable  = gate_q;
  assign motorRun    = running_q;
  assign cutoffWarn  = warn_q;
  assign cutoffFault = fault_q;
  assign faultCode   = faultCode_q;

  // ---------------------------------------------------------------------------
  // check helper: length of the current disagreement
  // ---------------------------------------------------------------------------
  // kept apart from the timer on purpose, so a wrong limit or a counter that
  // restarts late shows up as a failed check instead of a silent early trip;
  // it saturates rather than wraps, a stuck channel must not fake a short pulse
  logic [31:0] mismatchLen_q; // cycles the channels have differed before this one

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mismatchLen_q <= 32'h0000_0000;
    end else if (!mismatch) begin
      mismatchLen_q <= 32'h0000_0000;              // agreement restarts the count
    end else if (mismatchLen_q != 32'hFFFF_FFFF) begin
      mismatchLen_q <= mismatchLen_q + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_gate_open_off: assert property (@(posedge mclk) disable iff (!rst_b)
    anyOpen |=> !gateEnable) else $error("gate enable with cutoff open");

  a_start_refused: assert property (@(posedge mclk) disable iff (!rst_b)
    anyOpen && startReq |=> !motorRun) else $error("start accepted while open");

  a_restart_reset: assert property (@(posedge mclk) disable iff (!rst_b)
    state_q == DTCM_WAITRST && !resetCmd |=> state_q != DTCM_RUN_OK)
    else $error("restart without reset");

  a_priority_cut: assert property (@(posedge mclk) disable iff (!rst_b)
    gateEnable |-> $past(!anyOpen) && $past(driveEnReq))
    else $error("gate enabled without permission");

  a_mismatch_trip: assert property (@(posedge mclk) disable iff (!rst_b)
    mismatchExp |-> ##[1:2] (faultCode != FaultCodeNone && !gateEnable))
    else $error("fault reaction late");

  a_short_notrip: assert property (@(posedge mclk) disable iff (!rst_b)
    mismatchExp |-> mismatchLen_q >= MISMATCH_CYCLES)
    else $error("short mismatch tripped");

  a_code_channel: assert property (@(posedge mclk) disable iff (!rst_b)
    mismatchExp && faultCode_q == FaultCodeNone && !closed[0]
      |=> faultCode == FaultCodeFirst)
    else $error("wrong channel code");

  a_fault_ind: assert property (@(posedge mclk) disable iff (!rst_b)
    faultCode_q != FaultCodeNone |=> cutoffFault)
    else $error("fault indication missing");

  a_warn_ind: assert property (@(posedge mclk) disable iff (!rst_b)
    cutActive && indSel == IndSelWarn |=> cutoffWarn)
    else $error("warning indication missing");

  // a break seen by the synchroniser drops the gate on the same edge as the level falls
  a_break_gate_off: assert property (@(posedge mclk) disable iff (!rst_b)
    (|syncBus.chanBreak) |=> !gateEnable)
    else $error("gate enable after short break");

  // a held level start runs as soon as the monitor allows it
  a_held_start: assert property (@(posedge mclk) disable iff (!rst_b)
    state_q == DTCM_RUN_OK && !anyOpen && startReq |=> motorRun)
    else $error("held start not taken");

  // a running motor is left to coast: run status drops with any open channel
  a_coast_open: assert property (@(posedge mclk) disable iff (!rst_b)
    anyOpen |=> !motorRun)
    else $error("run kept while open");

  // mixed setting shows a fault while the motor turns
  a_mixed_running: assert property (@(posedge mclk) disable iff (!rst_b)
    cutActive && indSel == IndSelMixed && running_q |=> cutoffFault)
    else $error("running indication missing");

  // an expired detection time always ends in the faulted state
  a_trip_state: assert property (@(posedge mclk) disable iff (!rst_b)
    mismatchExp |=> state_q == DTCM_FAULTED)
    else $error("trip state missing");

  // no code appears without an expired detection time
  a_no_early_code: assert property (@(posedge mclk) disable iff (!rst_b)
    faultCode_q == FaultCodeNone && !mismatchExp |=> faultCode == FaultCodeNone)
    else $error("fault code without trip");

endmodule : dtcm_monitor

`default_nettype wire

//--- dtcm_pkg.sv
// Purpose: shared constants and types for the dual channel torque cutoff monitor
// Assumes: 50 MHz control clock
// Notes:   all timing counts derive from the required times and the clock period
`default_nettype none

package dtcm_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned ClkPeriodNs     = 20;       // control clock period
  localparam int unsigned ReactTimeUs     = 1000;     // shortest break to catch, 1 ms
  localparam int unsigned MismatchTimeMs  = 200;      // channels differ longer than this
  localparam int unsigned FaultReactMs    = 10;       // extra allowance after detection
  localparam int unsigned FaultIndMs      = 500;      // fault indication bound (less than)
  localparam int unsigned WarnIndMs       = 1000;     // warning indication bound (less than)

  // cycle counts: a least time rounds up, a longest time rounds down
  localparam int unsigned ReactCycles     = (ReactTimeUs * 1000) / ClkPeriodNs;
  localparam int unsigned MismatchCycles  = (MismatchTimeMs * 1000000 + ClkPeriodNs - 1)
                                            / ClkPeriodNs;
  localparam int unsigned FaultReactCycles = (FaultReactMs * 1000000) / ClkPeriodNs;
  localparam int unsigned FaultIndCycles  = (FaultIndMs * 1000000) / ClkPeriodNs - 1;
  localparam int unsigned WarnIndCycles   = (WarnIndMs * 1000000) / ClkPeriodNs - 1;

  // ---------------------------------------------------------------------------
  // indication selection encoding
  // ---------------------------------------------------------------------------
  localparam logic [1:0] IndSelNone  = 2'h0; // no indication
  localparam logic [1:0] IndSelFault = 2'h1; // fault in both states
  localparam logic [1:0] IndSelWarn  = 2'h2; // warning in both states
  localparam logic [1:0] IndSelMixed = 2'h3; // fault when running, warning when stopped

  // fault code values
  localparam logic [1:0] FaultCodeNone   = 2'h0;
  localparam logic [1:0] FaultCodeFirst  = 2'h1; // first_channel_mismatch_fault
  localparam logic [1:0] FaultCodeSecond = 2'h2; // second_channel_mismatch_fault

  // monitor state
  typedef enum logic [1:0] {
    DTCM_RUN_OK  = 2'b00,  // output stage may be enabled
    DTCM_CUTOFF  = 2'b01,  // torque_cutoff active
    DTCM_FAULTED = 2'b10,  // mismatch latched
    DTCM_WAITRST = 2'b11   // channels closed, waiting for reset
  } dtcm_state_t;

endpackage : dtcm_pkg

`default_nettype wire

//--- dtcm_switch_model.sv
// Purpose: behavioural safety switch feeding both cutoff channels
// Assumes: contacts move on mclk, 1 = closed
// Notes:   slowMode delays each contact change, like a sluggish relay
`default_nettype none

module dtcm_switch_model (
  // clock
  input  wire logic       mclk,
  // bench commands
  input  wire logic [1:0] openCmd,   // 1 = open that channel
  input  wire logic       slowMode,  // slow relay contacts
  // contacts
  output logic      [1:0] chanPin    // 1 = closed
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] pinQ = 2'h3;  // contacts start closed
  logic [1:0] dlyQ = 2'h0;  // slow contact delay count

  // one command word moves both contacts together; a single bit is a wiring fault
  always_ff @(posedge mclk) begin
    if (!slowMode || dlyQ == 2'h3) begin
      pinQ <= ~openCmd;
      dlyQ <= 2'h0;
    end else begin
      dlyQ <= dlyQ + 2'h1;
    end
  end

  assign chanPin = pinQ;
endmodule : dtcm_switch_model

`default_nettype wire

//--- dtcm_sync.sv
// Purpose: three stage synchroniser for both cutoff inputs
// Assumes: inputs asynchronous to mclk
// Notes:   a level counts once stages two and three agree
`default_nettype none

module dtcm_sync (
  // clock and reset
  input  wire logic  mclk,
  input  wire logic  rst_b,
  // raw channel pins
  input  wire logic  [1:0] chanPin,
  // synchronised levels
  dtcm_sync_if.src   syncOut
);
  import dtcm_pkg::*;

  // ---------------------------------------------------------------------------
  // per channel synchroniser
  // ---------------------------------------------------------------------------
  logic [1:0] stage1_q; // first flop, read only by stage2
  logic [1:0] stage2_q;
  logic [1:0] stage3_q;
  logic [1:0] level_q;  // agreed level

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gChan
      // reset to open: a cutoff is the safe assumption until the pins are seen
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          stage1_q[g] <= 1'b0;
          stage2_q[g] <= 1'b0;
          stage3_q[g] <= 1'b0;
          level_q[g]  <= 1'b0;
        end else begin
          stage1_q[g] <= chanPin[g];
          stage2_q[g] <= stage1_q[g];
          stage3_q[g] <= stage2_q[g];
          // update only when two and three agree
          if (stage2_q[g] == stage3_q[g]) begin
            level_q[g] <= stage3_q[g];
          end
        end
      end
      // opening edge: any break long enough for stages two and three to agree
      assign syncOut.chanBreak[g] = level_q[g] & ~stage3_q[g] & ~stage2_q[g];
    end
  endgenerate

  assign syncOut.chanClosed = level_q;

endmodule : dtcm_sync

`default_nettype wire

//--- dtcm_sync_if.sv
// Purpose: carries synchronised cutoff channel levels between modules
// Assumes: single clock domain mclk
// Notes:   one bit per channel, 1 = channel closed (energised)
`default_nettype none

interface dtcm_sync_if;
  logic [1:0] chanClosed;  // synchronised and agreed channel levels
  logic [1:0] chanBreak;   // one cycle pulse: channel seen opening

  modport src (output chanClosed, output chanBreak);
  modport dst (input chanClosed, input chanBreak);
endinterface : dtcm_sync_if

`default_nettype wire

//--- dtcm_tb.sv
// Purpose: self-checking bench for the torque cutoff monitor
// Assumes: 50 MHz mclk, mismatch time shortened to MM cycles
// Notes:   inputs change 2 ns after each rising edge
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dtcm_pkg::*;

  localparam int unsigned MM = 20;  // short mismatch time keeps the run brief

  logic       mclk = 1'b0, rst_b = 1'b0;              // clock, reset
  logic       startReq = 1'b1, resetCmd = 1'b0;       // drive commands
  logic       driveEnReq = 1'b1, slowMode = 1'b0;     // other drive request, relay speed
  logic [1:0] indSel = IndSelNone, openCmd = 2'h0;    // setting, switch command
  logic [1:0] chanPin, faultCode;                     // contacts, trip code
  logic       gateEnable, motorRun, cutoffWarn, cutoffFault;
  int         errorCnt = 0, checkCount = 0;           // mismatches, comparisons
  logic [7:0] lfsrQ = 8'h5C;                          // random source

  dtcm_monitor #(.MISMATCH_CYCLES(MM)) i_dtcm_monitor (
    .mclk(mclk), .rst_b(rst_b), .chanPin(chanPin), .startReq(startReq),
    .resetCmd(resetCmd), .driveEnReq(driveEnReq), .indSel(indSel),
    .gateEnable(gateEnable), .motorRun(motorRun), .cutoffWarn(cutoffWarn),
    .cutoffFault(cutoffFault), .faultCode(faultCode));

  dtcm_switch_model i_dtcm_switch_model (
    .mclk(mclk), .openCmd(openCmd), .slowMode(slowMode), .chanPin(chanPin));

  // free running clock
  initial begin
    forever #10 mclk = ~mclk;
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] lfsrNext(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsrNext

  // expected {warn, fault}; mixed setting tells running from stopped
  function automatic logic [1:0] indExp(input logic [1:0] sel, input logic running);
    case (sel)
      IndSelFault: return 2'h1;
      IndSelWarn:  return 2'h2;
      IndSelMixed: return running ? 2'h1 : 2'h2;
      default:     return 2'h0;
    endcase
  endfunction : indExp

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : tick

  task automatic end_of_test;
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic chk_code(input logic [1:0] got, input logic [1:0] exp);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error %0t: fault code %h expected %h", $time, got, exp);
    end
  endtask : chk_code

  // bounded wait on gate enable (0) or run status (1); a hang ends the run
  task automatic wait_for(input int which, input logic val, input int bound);
    int n;
    n = 0;
    while ((which == 0 ? gateEnable : motorRun) !== val && n < bound) begin
      tick(1);
      n++;
    end
    if ((which == 0 ? gateEnable : motorRun) !== val) begin
      errorCnt++;
      $display("Error %0t: wait on output %0d timed out", $time, which);
      end_of_test();
    end
  endtask : wait_for

  // open both, hold start, close both, show no restart, then reset and run
  task automatic bring_up;
    openCmd = 2'h3;
    resetCmd = 1'b0;
    startReq = 1'b1;
    driveEnReq = 1'b1;
    tick(12);
    chk_bit(motorRun, 1'b0, "start while open");
    openCmd = 2'h0;
    tick(12);
    chk_bit(gateEnable, 1'b0, "restart before reset");
    resetCmd = 1'b1;
    tick(1);
    resetCmd = 1'b0;
    wait_for(0, 1'b1, 10);
    chk_bit(motorRun, 1'b1, "held start runs");
  endtask : bring_up

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [1:0] e;
    repeat (3) @(posedge mclk);
    #2;
    chk_bit(gateEnable, 1'b0, "gate in reset");
    rst_b = 1'b1;
    bring_up();
    $display("test power up done");

    // cutoff for each setting, stopped with fast relay, then running with slow relay
    for (int s = 0; s < 4; s++) begin
      for (int r = 0; r < 2; r++) begin
        indSel = s[1:0];
        slowMode = r[0];
        bring_up();
        if (r == 0) begin
          startReq = 1'b0;
          wait_for(1, 1'b0, 10);
        end
        openCmd = 2'h3;
        tick(12);
        chk_bit(gateEnable, 1'b0, "gate after cutoff");
        e = indExp(s[1:0], r[0]);
        chk_bit(cutoffWarn, e[1], "warning");
        chk_bit(cutoffFault, e[0], "fault ind");
        // random commands while open must not enable anything
        repeat (12) begin
          lfsrQ = lfsrNext(lfsrQ);
          startReq = lfsrQ[0];
          driveEnReq = lfsrQ[1];
          resetCmd = lfsrQ[2];
          tick(1);
          chk_bit(gateEnable, 1'b0, "gate while open");
          chk_bit(motorRun, 1'b0, "run while open");
        end
      end
    end
    $display("test cutoff done");

    // single channel use, short and long
    slowMode = 1'b0;
    indSel = IndSelFault;
    for (int c = 0; c < 2; c++) begin
      bring_up();
      lfsrQ = lfsrNext(lfsrQ);
      openCmd = c[0] ? 2'h2 : 2'h1;
      tick(4 + int'(lfsrQ[2:0]));
      openCmd = 2'h0;
      tick(MM + 10);
      chk_code(faultCode, FaultCodeNone);
      bring_up();
      openCmd = c[0] ? 2'h2 : 2'h1;
      tick(MM);
      chk_code(faultCode, FaultCodeNone);
      tick(12);
      chk_code(faultCode, c[0] ? FaultCodeSecond : FaultCodeFirst);
      chk_bit(cutoffFault, 1'b1, "trip shown");
      chk_bit(gateEnable, 1'b0, "gate after trip");
      resetCmd = 1'b1;
      tick(2);
      resetCmd = 1'b0;
      chk_code(faultCode, c[0] ? FaultCodeSecond : FaultCodeFirst);
      openCmd = 2'h3;
      tick(8);
      resetCmd = 1'b1;
      tick(1);
      resetCmd = 1'b0;
      tick(2);
      chk_code(faultCode, FaultCodeNone);
    end
    // a two cycle break of both channels still cuts the gate and needs a reset
    bring_up();
    openCmd = 2'h3;
    tick(2);
    openCmd = 2'h0;
    tick(10);
    chk_bit(gateEnable, 1'b0, "gate after short break");
    bring_up();
    $display("test mismatch done");
    end_of_test();
  end
endmodule : tb

`default_nettype wire

//--- dtcm_timer.sv
// Purpose: saturating duration counter used for mismatch timing
// Assumes: count restarts whenever run drops
// Notes:   expired holds high while run stays high past the limit
`default_nettype none

module dtcm_timer #(
  parameter int unsigned LIMIT = 10,
  parameter int unsigned WIDTH = 24
) (
  // clock and reset
  input  wire logic  mclk,
  input  wire logic  rst_b,
  // control
  input  wire logic  run,
  // result
  output logic       expired
);
  import dtcm_pkg::*;

  logic [WIDTH-1:0] count_q; // cycles run has been high

  // ---------------------------------------------------------------------------
  // counter: clears when run is low, stops at the limit
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= '0;
    end else if (!run) begin
      count_q <= '0;
    end else if (count_q != WIDTH'(LIMIT)) begin
      count_q <= count_q + WIDTH'(1);
    end
  end

  // strictly longer than the limit before expiry
  assign expired = run && (count_q == WIDTH'(LIMIT));

endmodule : dtcm_timer

`default_nettype wire
